// *** src/rcu_pkg.sv ***
// Package of shared constants and types for the refresh control unit
package rcu_pkg;

  // ==========================================================
  // Register indices on the peripheral register port
  localparam logic [1:0] RCU_IDX_BASE     = 2'h0;
  localparam logic [1:0] RCU_IDX_INTERVAL = 2'h1;
  localparam logic [1:0] RCU_IDX_CONTROL  = 2'h2;
  localparam logic [1:0] RCU_IDX_ADDRESS  = 2'h3;

  // ==========================================================
  // Field layout
  localparam int RCU_CNT_W      = 9;
  localparam int RCU_ROW_W      = 12;
  localparam int RCU_BASE_W     = 7;
  localparam int RCU_ENABLE_BIT = 15;

  localparam logic [8:0]  RCU_CNT_RESET  = 9'h000;
  localparam logic [8:0]  RCU_CNT_ONE    = 9'h001;
  localparam logic [11:0] RCU_ROW_RESET  = 12'h000;
  localparam logic [6:0]  RCU_BASE_RESET = 7'h00;
  localparam logic [11:0] RCU_LFSR_TAPS  = 12'hE08;
  localparam logic [11:0] RCU_LFSR_STUCK = 12'hFFF;

  // ==========================================================
  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  idx;
    logic [15:0] wdata;
  } rcu_reg_req_t;

  // Refresh address as driven on the bus
  typedef struct packed {
    logic [6:0]  base;
    logic [11:0] row;
    logic        bit0;
  } rcu_addr_t;

  // Bus ownership states
  typedef enum logic [1:0] {
    RCU_OWN_IDLE,
    RCU_OWN_HELD,
    RCU_OWN_RETURN,
    RCU_OWN_REFRESH
  } rcu_own_t;

endpackage

// *** src/rcu_interval.sv ***
// Interval down-counter that raises periodic refresh requests
`timescale 1ns/1ps
module rcu_interval
  import rcu_pkg::*;
#(
  parameter int CNT_W = 9
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             fall_edge,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] reload,
  output logic      [CNT_W-1:0] count,
  output logic                  tick
);
  import rcu_pkg::*;

  // ==========================================================
  // Counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= RCU_CNT_RESET;
      tick  <= 1'b0;
    end
    else if (!enable)
    begin
      count <= RCU_CNT_RESET;
      tick  <= 1'b0;
    end
    else if (fall_edge)
    begin
      // Zero after enable acts as a load, like one
      if (count == RCU_CNT_ONE || count == RCU_CNT_RESET)
      begin
        count <= reload;
        tick  <= (count == RCU_CNT_ONE);
      end
      else
      begin
        count <= count - RCU_CNT_ONE;
        tick  <= 1'b0;
      end
    end
    else
      tick <= 1'b0;
  end

endmodule

// *** src/rcu_row_lfsr.sv ***
// Twelve-bit maximal-length row address counter
`timescale 1ns/1ps
module rcu_row_lfsr
  import rcu_pkg::*;
#(
  parameter int ROW_W = 12
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             advance,
  output logic      [ROW_W-1:0] row
);
  import rcu_pkg::*;

  logic feedback;

  // ==========================================================
  // Xnor feedback so the all-zero reset value sits in the sequence
  assign feedback = ~(^(row & RCU_LFSR_TAPS));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      row <= RCU_ROW_RESET;
    else if (advance)
      row <= {row[ROW_W-2:0], feedback};
  end

endmodule

// *** src/rcu_top.sv ***
// Refresh control unit: registers, request logic, bus hold arbitration
// Behaviour
// - Base, interval and control registers plus a readable refresh address register.
// - Base register supplies upper seven address bits, any 8 Kbyte boundary.
// - Row counter wrap never carries into the base bits.
// - Interval counter decrements on every falling output clock edge.
// - At count one raise a request and reload from interval register.
// - Larger interval gives proportionally longer request spacing.
// - Enable bit read/write anytime, starts and stops refresh, resets zero.
// - Low nine control bits read live counter, ignore writes, reset zero.
// - Clearing enable clears the counter and its readback bits.
// - Address register holds row bits driven on next refresh; reset zero.
// - Address bit zero always reads and drives as one.
// - Keep hold acknowledge while hold request stays, absent refresh request.
// - Refresh request during hold drops hold acknowledge.
// - Refresh cycle starts only after hold request drops.
// - Hold after refresh start is acknowledged once refresh completes.
// - Row bits come from a maximal-length feedback shift counter.
// - Requests not queued; row advances only after a run refresh cycle.
// - Refresh drives upper byte enable high, or refresh strobe low, and A0 high.
// - Refresh outranks other cycles and hold; run as dummy read.
`timescale 1ns/1ps
module rcu_top
  import rcu_pkg::*;
#(
  parameter bit BUS_8BIT = 1'b0
)
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                output_clock,
  input  wire rcu_pkg::rcu_reg_req_t reg_req,
  output logic              [15:0] reg_rdata,
  input  wire logic                hold_req,
  output logic                     hold_ack,
  input  wire logic                cpu_bus_req,
  output logic                     cpu_bus_grant,
  output logic                     refresh_cycle_start,
  input  wire logic                refresh_cycle_done,
  output logic                     refresh_busy,
  output rcu_pkg::rcu_addr_t       refresh_address,
  output logic                     dummy_read,
  output logic                     upper_byte_enable_n,
  output logic                     refresh_strobe_n
);
  import rcu_pkg::*;

  // ==========================================================
  // Reset release
  logic       rst_meta;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic       clk_meta;
  logic       clk_sync;
  logic       clk_prev;
  logic       hold_meta;
  logic       hold_sync;
  logic       fall_edge;

  // Output clock: a third flop keeps the previous level for edge detection
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_meta <= output_clock;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // ==========================================================
  // Hold request: a level, no edge needed
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
    end
    else
    begin
      hold_meta <= hold_req;
      hold_sync <= hold_meta;
    end
  end

  // Flops reset low, so a pin idling high shows a rise, never a false fall
  assign fall_edge = clk_prev & ~clk_sync;

  // ==========================================================
  // Registers
  logic [6:0]  base_addr;
  logic [8:0]  interval;
  logic        enable;
  logic [8:0]  count;
  logic [11:0] row;
  logic        tick;

  function automatic logic is_write(input rcu_reg_req_t r, input logic [1:0] idx);
    is_write = r.wr && (r.idx == idx);
  endfunction

  // ==========================================================
  // Base register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      base_addr <= RCU_BASE_RESET;
    else if (is_write(reg_req, RCU_IDX_BASE))
      base_addr <= reg_req.wdata[RCU_BASE_W-1:0];
  end

  // ==========================================================
  // Interval register: a new value counts from the next reload
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      interval <= RCU_CNT_RESET;
    else if (is_write(reg_req, RCU_IDX_INTERVAL))
      interval <= reg_req.wdata[RCU_CNT_W-1:0];
  end

  // ==========================================================
  // Enable: counter bits and reserved bits of the write are dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable <= 1'b0;
    else if (is_write(reg_req, RCU_IDX_CONTROL))
      enable <= reg_req.wdata[RCU_ENABLE_BIT];
  end

  // ==========================================================
  // Readback
  function automatic logic [15:0] read_word(input logic [1:0] idx);
    unique case (idx)
      RCU_IDX_BASE:     read_word = {9'h000, base_addr};
      RCU_IDX_INTERVAL: read_word = {7'h00, interval};
      RCU_IDX_CONTROL:  read_word = {enable, 6'h00, count};
      RCU_IDX_ADDRESS:  read_word = {3'h0, row, 1'b1};
    endcase
  endfunction

  // Registered so the data output comes from flops; holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_req.rd)
      reg_rdata <= read_word(reg_req.idx);
  end

  // ==========================================================
  // Interval counter and row counter
  rcu_interval #(
    .CNT_W (RCU_CNT_W)
  ) u_interval (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .fall_edge (fall_edge),
    .enable    (enable),
    .reload    (interval),
    .count     (count),
    .tick      (tick)
  );

  rcu_row_lfsr #(
    .ROW_W (RCU_ROW_W)
  ) u_row (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .advance (refresh_cycle_done & refresh_busy),
    .row     (row)
  );

  // ==========================================================
  // Pending request: one deep, a new tick merges into it
  logic pending;
  logic take;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pending <= 1'b0;
    else if (!enable)
      pending <= 1'b0;
    else if (tick)
      pending <= 1'b1;
    else if (take)
      pending <= 1'b0;
  end

  // ==========================================================
  // Bus ownership
  rcu_own_t state;
  rcu_own_t next_state;

  always_comb
  begin
    next_state = state;
    take       = 1'b0;
    unique case (state)
      RCU_OWN_IDLE:
        // Refresh outranks hold and core cycles
        if (pending)
        begin
          next_state = RCU_OWN_REFRESH;
          take       = 1'b1;
        end
        else if (hold_sync)
          next_state = RCU_OWN_HELD;
      RCU_OWN_HELD:
        if (pending)
          next_state = RCU_OWN_RETURN;
        else if (!hold_sync)
          next_state = RCU_OWN_IDLE;
      RCU_OWN_RETURN:
        // Waits on the master; a master that never lets go stalls refresh
        if (!pending)
          next_state = hold_sync ? RCU_OWN_HELD : RCU_OWN_IDLE;
        else if (!hold_sync)
        begin
          next_state = RCU_OWN_REFRESH;
          take       = 1'b1;
        end
      RCU_OWN_REFRESH:
        if (refresh_cycle_done)
          next_state = hold_sync ? RCU_OWN_HELD : RCU_OWN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= RCU_OWN_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // Bus outputs
  // Acknowledge mirrors the held state, so it is never up during refresh
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_ack <= 1'b0;
    else
      hold_ack <= (next_state == RCU_OWN_HELD);
  end

  // ==========================================================
  // Refresh cycle start
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      refresh_cycle_start <= 1'b0;
    else
      refresh_cycle_start <= take;
  end

  // ==========================================================
  // Refresh address: base kept apart from the row, so a row wrap never carries
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      refresh_address <= {RCU_BASE_RESET, RCU_ROW_RESET, 1'b1};
    else
      refresh_address <= {base_addr, row, 1'b1};
  end

  assign refresh_busy        = (state == RCU_OWN_REFRESH);
  assign dummy_read          = refresh_busy;
  assign cpu_bus_grant       = cpu_bus_req && (state == RCU_OWN_IDLE) && !pending;
  assign upper_byte_enable_n = refresh_busy;
  assign refresh_strobe_n    = ~(refresh_busy & BUS_8BIT);

endmodule

// *** bench/rcu_partner.sv ***
// Alternate bus master and external refresh cycle logic
`timescale 1ns/1ps
module rcu_partner
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic hold_on,
  input  wire logic hold_ack,
  input  wire logic refresh_busy,
  output logic      hold_req,
  output logic      refresh_cycle_done
);
  logic       ack_q;
  logic [2:0] lag;
  logic [2:0] cnt;
  // ==========================================================
  // Hold owner: gives the bus back 5 cycles after losing ack
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q    <= 1'b0;
      lag      <= 3'h0;
      hold_req <= 1'b0;
    end
    else
    begin
      ack_q <= hold_ack;
      if (refresh_busy)
        lag <= 3'h0;
      else if (lag != 3'h0 && lag != 3'h4)
        lag <= lag + 3'h1;
      else if (ack_q && !hold_ack && hold_req)
        lag <= 3'h1;
      hold_req <= hold_on && (lag != 3'h4);
    end
  end
  // ==========================================================
  // Refresh cycle ends a few cycles in, so a new hold is seen
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt                <= 3'h0;
      refresh_cycle_done <= 1'b0;
    end
    else
    begin
      cnt                <= (refresh_busy && !refresh_cycle_done) ? cnt + 3'h1 : 3'h0;
      refresh_cycle_done <= refresh_busy && !refresh_cycle_done && cnt == 3'h5;
    end
  end
endmodule

// *** bench/rcu_top_chk.sv ***
// Concurrent checks on the refresh control unit ports
`timescale 1ns/1ps
module rcu_top_chk
  import rcu_pkg::*;
#(
  parameter bit BUS_8BIT = 1'b0
)
(
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire rcu_pkg::rcu_reg_req_t reg_req,
  input wire logic                  hold_req,
  input wire logic                  hold_ack,
  input wire logic                  cpu_bus_grant,
  input wire logic                  refresh_cycle_start,
  input wire logic                  refresh_cycle_done,
  input wire logic                  refresh_busy,
  input wire rcu_pkg::rcu_addr_t    refresh_address,
  input wire logic                  dummy_read
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  sequence s_run;
    refresh_cycle_start ##[0:1] refresh_busy;
  endsequence
  a_start_busy: assert property (refresh_cycle_start |-> s_run)
    else $error("refresh start without busy");
  a_busy_holds: assert property (refresh_busy && !refresh_cycle_done |=> refresh_busy)
    else $error("refresh ended before done");
  a_start_free: assert property (refresh_cycle_start |-> !hold_req && !hold_ack)
    else $error("refresh started while hold");
  a_busy_no_ack: assert property (refresh_busy |-> !hold_ack)
    else $error("hold ack during refresh");
  a_busy_no_grant: assert property (refresh_busy |-> !cpu_bus_grant)
    else $error("core granted during refresh");
  a_dummy_read: assert property (dummy_read == refresh_busy)
    else $error("dummy read mismatch");
  a_bit_zero: assert property (refresh_busy |-> refresh_address.bit0)
    else $error("address bit zero low");
  a_row_advance: assert property ($changed(refresh_address.row)
    |-> $past(refresh_busy, 2))
    else $error("row moved without refresh");
  a_base_kept: assert property ($changed(refresh_address.base)
    |-> $past(reg_req.wr) || $past(reg_req.wr, 2) || $past(reg_req.wr, 3))
    else $error("base changed without write");
endmodule
bind rcu_top rcu_top_chk #(.BUS_8BIT(BUS_8BIT)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_req(reg_req), .hold_req(hold_req), .hold_ack(hold_ack), .cpu_bus_grant(cpu_bus_grant),
  .refresh_cycle_start(refresh_cycle_start), .refresh_cycle_done(refresh_cycle_done),
  .refresh_busy(refresh_busy), .refresh_address(refresh_address), .dummy_read(dummy_read));

// *** bench/rcu_top_tb.sv ***
// Self-checking testbench for the refresh control unit
`timescale 1ns/1ps
module rcu_top_tb;
  import rcu_pkg::*;
  logic         ref_clk, reset_n, output_clock, hold_on, hold_req, hold_ack;
  logic         cpu_bus_grant, refresh_cycle_start, refresh_cycle_done, refresh_busy;
  logic         dummy_read, upper_byte_enable_n, refresh_strobe_n, cpu_bus_req;
  logic [15:0]  reg_rdata, q, r0;
  rcu_reg_req_t reg_req;
  rcu_addr_t    refresh_address;
  int           fail_count, checked, cycles, n;
  rcu_top #(.BUS_8BIT(1'b0)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .output_clock(output_clock), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .hold_req(hold_req), .hold_ack(hold_ack), .cpu_bus_req(cpu_bus_req),
    .cpu_bus_grant(cpu_bus_grant), .refresh_cycle_start(refresh_cycle_start),
    .refresh_cycle_done(refresh_cycle_done), .refresh_busy(refresh_busy),
    .refresh_address(refresh_address), .dummy_read(dummy_read),
    .upper_byte_enable_n(upper_byte_enable_n), .refresh_strobe_n(refresh_strobe_n));
  rcu_partner far_end (.ref_clk(ref_clk), .rst_n(reset_n), .hold_on(hold_on),
    .hold_ack(hold_ack), .refresh_busy(refresh_busy), .hold_req(hold_req),
    .refresh_cycle_done(refresh_cycle_done));
  // ==========================================================
  // Clocks: output clock runs at a quarter of the system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always
  begin
    repeat (2) @(posedge ref_clk);
    #1 output_clock = ~output_clock;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================================
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Trailing idle cycle keeps two requests from sharing a time step
  task automatic req(input logic w, input logic [1:0] idx, input logic [15:0] d);
    reg_req = '{wr: w, rd: !w, idx: idx, wdata: d};
    cyc(1);
    reg_req = '0;
    q = reg_rdata;
    cyc(1);
  endtask
  task automatic wait_start(input int lim);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (refresh_cycle_start !== 1'b1 && n < lim);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  task automatic t_reset;
    req(1'b0, RCU_IDX_CONTROL, 16'h0000);
    chk("control", q, 20'h00000);
    req(1'b0, RCU_IDX_ADDRESS, 16'h0000);
    chk("address", q, 20'h00001);
    chk("grant idle", cpu_bus_grant, 20'h00001);
    $display("test reset done");
  endtask
  task automatic t_regs;
    req(1'b1, RCU_IDX_CONTROL, 16'h01FF);
    req(1'b0, RCU_IDX_CONTROL, 16'h0000);
    chk("count write", q, 20'h00000);
    req(1'b1, RCU_IDX_BASE, 16'h0055);
    req(1'b1, RCU_IDX_INTERVAL, 16'h0004);
    req(1'b0, RCU_IDX_ADDRESS, 16'h0000);
    r0 = q;
    req(1'b1, RCU_IDX_CONTROL, 16'h8000);
    req(1'b0, RCU_IDX_CONTROL, 16'h0000);
    chk("enable", q[15:9], 20'h00040);
    wait_start(200);
    chk("start", refresh_cycle_start, 20'h00001);
    chk("refresh addr", refresh_address, {7'h55, r0[12:1], 1'b1});
    chk("strobes", {upper_byte_enable_n, refresh_strobe_n}, 20'h00003);
    chk("dummy read", dummy_read, 20'h00001);
    chk("grant in refresh", cpu_bus_grant, 20'h00000);
    cyc(10);
    req(1'b0, RCU_IDX_ADDRESS, 16'h0000);
    chk("row moved", q[12:1] != r0[12:1], 20'h00001);
    $display("test registers done");
  endtask
  task automatic t_spacing;
    for (int i = 0; i < 2; i++)
    begin
      req(1'b1, RCU_IDX_INTERVAL, (i == 0) ? 16'h0004 : 16'h0008);
      wait_start(200);
      wait_start(200);
      wait_start(200);
      chk("spacing", n[19:0], (i == 0) ? 20'd16 : 20'd32);
    end
    $display("test spacing done");
  endtask
  task automatic t_disable;
    req(1'b1, RCU_IDX_CONTROL, 16'h0000);
    req(1'b0, RCU_IDX_CONTROL, 16'h0000);
    chk("disabled", q, 20'h00000);
    wait_start(100);
    chk("no start", refresh_cycle_start, 20'h00000);
    $display("test disable done");
  endtask
  task automatic t_hold;
    hold_on = 1'b1;
    cyc(30);
    chk("hold kept", hold_ack, 20'h00001);
    req(1'b1, RCU_IDX_CONTROL, 16'h8000);
    wait_start(300);
    chk("start after hold", refresh_cycle_start, 20'h00001);
    n = 0;
    while (refresh_busy === 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk("ack after refresh", hold_ack, 20'h00001);
    hold_on = 1'b0;
    req(1'b1, RCU_IDX_CONTROL, 16'h0000);
    $display("test hold done");
  endtask
  // ==========================================================
  initial
  begin
    reset_n = 1'b0;
    output_clock = 1'b1;
    hold_on = 1'b0;
    cpu_bus_req = 1'b1;
    reg_req = '0;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    cyc(12);
    reset_n = 1'b1;
    cyc(4);
    t_reset();
    t_regs();
    t_spacing();
    t_disable();
    t_hold();
    conclude();
  end
endmodule
